/* File: core/iwd_pkg.sv */
// constants, types and register map of the independent watchdog register block
package iwd_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned SYS_CLK_PERIOD_NS = 100;
  localparam int unsigned OSC_PERIOD_NS     = 25000;
  localparam int unsigned OSC_TICK_CYCLES   = OSC_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam logic [7:0]  OSC_TICK_LAST     = 8'(OSC_TICK_CYCLES - 1);
  localparam logic [2:0]  XFER_TICKS_LAST   = 3'h2;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 5;
  localparam logic [4:0]  OFF_KEY = 5'h00;
  localparam logic [4:0]  OFF_DIV = 5'h04;
  localparam logic [4:0]  OFF_RLD = 5'h08;
  localparam logic [4:0]  OFF_FLG = 5'h0c;
  localparam logic [4:0]  OFF_BND = 5'h10;

  localparam logic [15:0] KEY_RELOAD = 16'haaaa;
  localparam logic [15:0] KEY_UNLOCK = 16'h5555;
  localparam logic [15:0] KEY_START  = 16'hcccc;

  localparam int unsigned CNT_W      = 12;
  localparam int unsigned DIV_W      = 3;
  localparam logic [11:0] RELOAD_RST = 12'hfff;
  localparam logic [11:0] BOUND_RST  = 12'hfff;
  localparam logic [11:0] DIV_RST    = 12'h000;
  localparam logic [11:0] CNT_START  = 12'hfff;
  localparam logic [11:0] CNT_ZERO   = 12'h000;
  localparam logic [2:0]  DIV_SEL_MAX = 3'h6;
  localparam logic [8:0]  DIV_BASE    = 9'h004;

  // transfer channels, also the bit positions of the pending flags in the OFF_FLG read
  localparam int unsigned CH_DIV = 0;
  localparam int unsigned CH_RLD = 1;
  localparam int unsigned CH_BND = 2;
  localparam int unsigned NUM_CH = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } iwd_wr_s;

  typedef enum logic {WR_COLLECT, WR_RESP} iwd_wr_e;
  typedef enum logic {RD_IDLE, RD_RESP}    iwd_rd_e;

endpackage

/* File: core/iwd_xfer.sv */
// one setting carried from the bus side into the oscillator-tick side with a pending flag
`timescale 1ns/1ps
module iwd_xfer
  import iwd_pkg::*;
#(
  parameter logic [CNT_W-1:0] RST_VAL = 12'h000
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // oscillator tick and standby restore
  input  wire logic             i_osc_tick,
  input  wire logic             i_restore,
  // bus side
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_data,
  output logic                  o_pending,
  // oscillator side
  output logic [CNT_W-1:0]      o_shadow,
  output logic                  o_applied
);

  // ---------------------------------------------------------------------------
  // handshake state
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] stage_reg,  stage_next;
  logic [CNT_W-1:0] shadow_reg, shadow_next;
  logic             pend_reg,   pend_next;
  logic [2:0]       ticks_reg,  ticks_next;
  logic             applied_reg, applied_next;

  // request stays up until the tick side has taken the value over
  always_comb begin
    stage_next   = stage_reg;
    shadow_next  = shadow_reg;
    pend_next    = pend_reg;
    ticks_next   = ticks_reg;
    applied_next = 1'b0;
    if (i_load && !pend_reg) begin
      stage_next = i_data;
      pend_next  = 1'b1;
      ticks_next = 3'h0;
    end else if (pend_reg && i_osc_tick) begin
      // three ticks, inside the five-tick budget
      if (ticks_reg == XFER_TICKS_LAST) begin
        shadow_next  = stage_reg;
        pend_next    = 1'b0;
        applied_next = 1'b1;
      end else begin
        ticks_next = ticks_reg + 3'h1;
      end
    end
    // standby puts the value back but leaves the flag alone
    if (i_restore) begin
      shadow_next = RST_VAL;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      stage_reg   <= RST_VAL;
      shadow_reg  <= RST_VAL;
      pend_reg    <= 1'b0;
      ticks_reg   <= 3'h0;
      applied_reg <= 1'b0;
    end else if (i_ce) begin
      stage_reg   <= stage_next;
      shadow_reg  <= shadow_next;
      pend_reg    <= pend_next;
      ticks_reg   <= ticks_next;
      applied_reg <= applied_next;
    end
  end

  assign o_pending = pend_reg;
  assign o_shadow  = shadow_reg;
  assign o_applied = applied_reg;

endmodule

/* File: core/iwd_top.sv */
// independent watchdog: axi4-lite registers, setting transfers and downcounter
//
// Functional notes
// - reload key copies the reload value into the downcounter.
// - reload value is writable only while access is unlocked.
// - reload write taken only while its pending flag is clear.
// - reload read returns the tick-side copy.
// - divider pending flag set on write, cleared within five ticks.
// - reload pending flag set on write, cleared within five ticks.
// - bound pending flag set on write, cleared within five ticks.
// - bound pending flag exists only with the window option enabled.
// - bound write taken only while its pending flag is clear.
// - status clears on system reset, survives standby.
// - counter compared with upper bound; reload valid at or below it.
// - bound read returns the tick-side copy.
// - key 0x00, divider 0x04, reload 0x08, status 0x0c, bound 0x10.
// - timeout set by reload value and divider on the tick.
// - start key runs counter from 0xfff; zero raises watchdog reset.
// - unlock key opens the three registers; other keys relock.
// - reload key while running with the count above the bound raises watchdog reset.
// - a bound change reloads the counter.
`timescale 1ns/1ps
module iwd_top
  import iwd_pkg::*;
#(
  parameter bit WINDOW_EN = 1'b1
) (
  // clock, reset, enable
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  // standby exit restore pulse
  input  wire logic              i_standby,
  // axi4-lite write address
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  // axi4-lite write data
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  // axi4-lite write response
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  output logic [1:0]             o_s_axi_bresp,
  // axi4-lite read
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  // watchdog state
  output logic                   o_wdg_reset,
  output logic                   o_running,
  output logic [CNT_W-1:0]       o_count
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  iwd_wr_e          wr_state_reg, wr_state_next;
  iwd_rd_e          rd_state_reg, rd_state_next;
  iwd_wr_s          wr_hold_reg,  wr_hold_next;
  logic             aw_have_reg,  aw_have_next;
  logic             w_have_reg,   w_have_next;
  logic [1:0]       bresp_reg,    bresp_next;
  logic [31:0]      rdata_reg,    rdata_next;
  logic [1:0]       rresp_reg,    rresp_next;
  logic             unlock_reg,   unlock_next;
  logic             run_reg,      run_next;
  logic [CNT_W-1:0] cnt_reg,      cnt_next;
  logic [7:0]       pre_reg,      pre_next;
  logic [7:0]       osc_reg,      osc_next;
  logic             wdg_reg,      wdg_next;

  logic             osc_tick;
  logic             wr_fire;
  logic             wr_mapped;
  logic [15:0]      key_val;
  logic [CNT_W-1:0] merged [NUM_CH];
  logic [CNT_W-1:0] wr_val [NUM_CH];
  logic [CNT_W-1:0] shadow [NUM_CH];
  logic [NUM_CH-1:0] load;
  logic [NUM_CH-1:0] pending;
  logic [NUM_CH-1:0] applied;
  logic [4:0]        ch_off [NUM_CH];
  logic [DIV_W-1:0]  div_sel;
  logic [8:0]        pre_last;

  assign ch_off[CH_DIV] = OFF_DIV;
  assign ch_off[CH_RLD] = OFF_RLD;
  assign ch_off[CH_BND] = OFF_BND;

  // ---------------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------------
  // both halves collected; the write acts in this cycle
  assign wr_fire   = (wr_state_reg == WR_COLLECT) && aw_have_reg && w_have_reg;
  assign wr_mapped = (wr_hold_reg.addr <= OFF_BND) && (wr_hold_reg.addr[1:0] == 2'h0);
  // lanes not strobed count as zero so a partial key never matches
  assign key_val   = {wr_hold_reg.strb[1] ? wr_hold_reg.data[15:8] : 8'h00,
                      wr_hold_reg.strb[0] ? wr_hold_reg.data[7:0]  : 8'h00};

  // ---------------------------------------------------------------------------
  // per-setting transfer channels
  // ---------------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
      // byte-lane merge over the present copy
      assign merged[ch] = {wr_hold_reg.strb[1] ? wr_hold_reg.data[11:8] : shadow[ch][11:8],
                           wr_hold_reg.strb[0] ? wr_hold_reg.data[7:0]  : shadow[ch][7:0]};
      assign wr_val[ch] = (ch == CH_DIV) ? {9'h000, merged[ch][DIV_W-1:0]} : merged[ch];
      // locked or busy writes are dropped without an error answer
      assign load[ch]   = wr_fire && (wr_hold_reg.addr == ch_off[ch]) && unlock_reg
                          && !pending[ch];
      if (ch == CH_BND && !WINDOW_EN) begin : g_absent
        // no window option: flag absent, bound fixed at its reset value
        assign pending[ch] = 1'b0;
        assign shadow[ch]  = BOUND_RST;
        assign applied[ch] = 1'b0;
      end else begin : g_xfer
        iwd_xfer #(
          .RST_VAL ((ch == CH_DIV) ? DIV_RST : ((ch == CH_RLD) ? RELOAD_RST : BOUND_RST))
        ) u_xfer (
          .i_sys_clk  (i_sys_clk),
          .i_rst      (i_rst),
          .i_ce       (i_ce),
          .i_osc_tick (osc_tick),
          .i_restore  (i_standby && (ch != CH_DIV)),
          .i_load     (load[ch]),
          .i_data     (wr_val[ch]),
          .o_pending  (pending[ch]),
          .o_shadow   (shadow[ch]),
          .o_applied  (applied[ch])
        );
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------------------
  // one write and one read in flight; address and data may come in either order
  always_comb begin
    wr_state_next = wr_state_reg;
    rd_state_next = rd_state_reg;
    wr_hold_next  = wr_hold_reg;
    aw_have_next  = aw_have_reg;
    w_have_next   = w_have_reg;
    bresp_next    = bresp_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    unlock_next   = unlock_reg;
    case (wr_state_reg)
      WR_COLLECT: begin
        if (i_s_axi_awvalid && !aw_have_reg) begin
          wr_hold_next.addr = i_s_axi_awaddr;
          aw_have_next      = 1'b1;
        end
        if (i_s_axi_wvalid && !w_have_reg) begin
          wr_hold_next.data = i_s_axi_wdata;
          wr_hold_next.strb = i_s_axi_wstrb;
          w_have_next       = 1'b1;
        end
        if (wr_fire) begin
          aw_have_next  = 1'b0;
          w_have_next   = 1'b0;
          bresp_next    = wr_mapped ? RESP_OKAY : RESP_SLVERR;
          wr_state_next = WR_RESP;
          if (wr_hold_reg.addr == OFF_KEY) begin
            unlock_next = (key_val == KEY_UNLOCK);
          end
        end
      end
      WR_RESP: begin
        if (i_s_axi_bready) begin
          wr_state_next = WR_COLLECT;
        end
      end
      default: begin
        wr_state_next = WR_COLLECT;
      end
    endcase
    case (rd_state_reg)
      RD_IDLE: begin
        if (i_s_axi_arvalid) begin
          rresp_next    = RESP_OKAY;
          rd_state_next = RD_RESP;
          case (i_s_axi_araddr)
            OFF_KEY: rdata_next = 32'h0000_0000;
            OFF_DIV: rdata_next = {29'h0000_0000, shadow[CH_DIV][DIV_W-1:0]};
            OFF_RLD: rdata_next = {20'h00000, shadow[CH_RLD]};
            OFF_FLG: rdata_next = {29'h0000_0000, pending};
            OFF_BND: rdata_next = {20'h00000, shadow[CH_BND]};
            default: begin
              rdata_next = 32'h0000_0000;
              rresp_next = RESP_SLVERR;
            end
          endcase
        end
      end
      RD_RESP: begin
        if (i_s_axi_rready) begin
          rd_state_next = RD_IDLE;
        end
      end
      default: begin
        rd_state_next = RD_IDLE;
      end
    endcase
    // leaving standby closes register access again
    if (i_standby) begin
      unlock_next = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_state_reg <= WR_COLLECT;
      rd_state_reg <= RD_IDLE;
      wr_hold_reg  <= '0;
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
      rdata_reg    <= 32'h0000_0000;
      rresp_reg    <= RESP_OKAY;
      unlock_reg   <= 1'b0;
    end else if (i_ce) begin
      wr_state_reg <= wr_state_next;
      rd_state_reg <= rd_state_next;
      wr_hold_reg  <= wr_hold_next;
      aw_have_reg  <= aw_have_next;
      w_have_reg   <= w_have_next;
      bresp_reg    <= bresp_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      unlock_reg   <= unlock_next;
    end
  end

  // handshakes close while the enable is low, so a frozen slave neither takes nor answers
  assign o_s_axi_awready = i_ce && (wr_state_reg == WR_COLLECT) && !aw_have_reg;
  assign o_s_axi_wready  = i_ce && (wr_state_reg == WR_COLLECT) && !w_have_reg;
  assign o_s_axi_bvalid  = i_ce && (wr_state_reg == WR_RESP);
  assign o_s_axi_bresp   = bresp_reg;
  assign o_s_axi_arready = i_ce && (rd_state_reg == RD_IDLE);
  assign o_s_axi_rvalid  = i_ce && (rd_state_reg == RD_RESP);
  assign o_s_axi_rdata   = rdata_reg;
  assign o_s_axi_rresp   = rresp_reg;

  // ---------------------------------------------------------------------------
  // oscillator tick, divider and downcounter
  // ---------------------------------------------------------------------------
  // the rc oscillator is modelled as a tick derived from the system clock,
  // so its rate tracks this clock and not a real rc part
  assign osc_tick = (osc_reg == OSC_TICK_LAST);
  // settings seven and six both divide by 256
  assign div_sel  = (shadow[CH_DIV][DIV_W-1:0] > DIV_SEL_MAX) ? DIV_SEL_MAX : shadow[CH_DIV][DIV_W-1:0];
  assign pre_last = (DIV_BASE << div_sel) - 9'h001;

  always_comb begin
    osc_next = osc_tick ? 8'h00 : (osc_reg + 8'h01);
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    run_next = run_reg;
    wdg_next = wdg_reg;
    if (run_reg && osc_tick) begin
      if ({1'b0, pre_reg} == pre_last) begin
        pre_next = 8'h00;
        if (cnt_reg != CNT_ZERO) begin
          cnt_next = cnt_reg - 12'h001;
        end
      end else begin
        pre_next = pre_reg + 8'h01;
      end
    end
    if (run_reg && (cnt_reg == CNT_ZERO)) begin
      wdg_next = 1'b1;
    end
    if (wr_fire && (wr_hold_reg.addr == OFF_KEY)) begin
      if ((key_val == KEY_START) && !run_reg) begin
        run_next = 1'b1;
        cnt_next = CNT_START;
        pre_next = 8'h00;
      end else if (key_val == KEY_RELOAD) begin
        if (run_reg && (cnt_reg > shadow[CH_BND])) begin
          wdg_next = 1'b1;
        end else begin
          cnt_next = shadow[CH_RLD];
          pre_next = 8'h00;
        end
      end
    end
    // a new bound takes effect together with a fresh reload
    if (applied[CH_BND]) begin
      cnt_next = shadow[CH_RLD];
      pre_next = 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      osc_reg <= 8'h00;
      pre_reg <= 8'h00;
      cnt_reg <= CNT_START;
      run_reg <= 1'b0;
      wdg_reg <= 1'b0;
    end else if (i_ce) begin
      osc_reg <= osc_next;
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      wdg_reg <= wdg_next;
    end
  end

  assign o_wdg_reset = wdg_reg;
  assign o_running   = run_reg;
  assign o_count     = cnt_reg;

endmodule

/* File: verification/iwd_top_assertions.sv */
// concurrent checks on the ports of the watchdog register block
`timescale 1ns/1ps
module iwd_top_assertions
  import iwd_pkg::*;
(
  // clock, reset, enable, standby
  input wire logic i_sys_clk, i_rst, i_ce, i_standby,
  // axi4-lite write side
  input wire logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic o_s_axi_bvalid, i_s_axi_bready,
  input wire logic [1:0] o_s_axi_bresp,
  // axi4-lite read side
  input wire logic i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid, i_s_axi_rready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  // watchdog state
  input wire logic o_wdg_reset, o_running,
  input wire logic [CNT_W-1:0] o_count
);
  // ---------------------------------------------------------------------------
  // handshake helpers
  // ---------------------------------------------------------------------------
  // a frozen clock enable holds every state, so checks pause with it
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || !i_ce);
  wire wr_both = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  wire rd_take = i_s_axi_arvalid && o_s_axi_arready;
  wire start_wr = wr_both && i_s_axi_awaddr == OFF_KEY && i_s_axi_wdata[15:0] == KEY_START
                  && i_s_axi_wstrb[1:0] == 2'h3 && !o_running && !o_wdg_reset;

  // ---------------------------------------------------------------------------
  // bus timing and decode
  // ---------------------------------------------------------------------------
  AST_B_LATENCY: assert property (wr_both |=> !o_s_axi_bvalid ##1 o_s_axi_bvalid)
    else $error("write response not two cycles after the write was taken");
  AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped or changed before bready");
  AST_R_LATENCY: assert property (rd_take |=> o_s_axi_rvalid)
    else $error("read data not one cycle after the address was taken");
  AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped or changed before rready");
  AST_R_UNMAPPED: assert property (rd_take && i_s_axi_araddr > OFF_BND |=>
                                   o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0)
    else $error("unmapped read not refused with zero data");
  AST_KEY_READ: assert property (rd_take && i_s_axi_araddr == OFF_KEY |=> o_s_axi_rdata == 32'h0)
    else $error("key register read not zero");

  // ---------------------------------------------------------------------------
  // downcounter
  // ---------------------------------------------------------------------------
  AST_START_FULL: assert property (start_wr |-> ##[1:2] (o_running && o_count == CNT_START))
    else $error("start key did not run the counter from full scale");
  AST_ZERO_FIRES: assert property (o_running && o_count == CNT_ZERO |=> o_wdg_reset)
    else $error("count at zero did not raise the watchdog reset");
  AST_RESET_STICKY: assert property (o_wdg_reset |=> o_wdg_reset)
    else $error("watchdog reset released without system reset");

  // main scenarios reached
  cover property (wr_both);
  cover property (o_s_axi_rvalid && o_s_axi_rresp == RESP_SLVERR);
  cover property ($rose(o_wdg_reset));
endmodule

/* File: verification/test_iwd_top.sv */
// self-checking bench for the watchdog register block
`timescale 1ns/1ps
module test_iwd_top;
  import iwd_pkg::*;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
  typedef struct { logic [4:0] a; logic [31:0] d; logic [1:0] r; } iwd_row_s;

  logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_standby = 1'b0;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [4:0]  aw_a = 5'h00, ar_a = 5'h00;
  logic [31:0] w_d = 32'h0, r_dat;
  logic [3:0]  w_s = 4'hf;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, wdg, run;
  logic [1:0]  b_resp, r_resp, b_last;
  logic [11:0] cnt;
  int          fail_count = 0, n_checks = 0, cyc = 0, t0, n;
  // reset-time reads: every mapped place, then unmapped and misaligned ones
  iwd_row_s rows[7] = '{'{OFF_KEY, 32'h0, RESP_OKAY}, '{OFF_DIV, 32'h0, RESP_OKAY},
    '{OFF_RLD, 32'hfff, RESP_OKAY}, '{OFF_FLG, 32'h0, RESP_OKAY}, '{OFF_BND, 32'hfff, RESP_OKAY},
    '{5'h14, 32'h0, RESP_SLVERR}, '{5'h06, 32'h0, RESP_SLVERR}};

  iwd_top dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_standby(i_standby),
    .i_s_axi_awvalid(aw_v), .o_s_axi_awready(aw_rdy), .i_s_axi_awaddr(aw_a),
    .i_s_axi_wvalid(w_v), .o_s_axi_wready(w_rdy), .i_s_axi_wdata(w_d), .i_s_axi_wstrb(w_s),
    .o_s_axi_bvalid(b_v), .i_s_axi_bready(b_r), .o_s_axi_bresp(b_resp),
    .i_s_axi_arvalid(ar_v), .o_s_axi_arready(ar_rdy), .i_s_axi_araddr(ar_a),
    .o_s_axi_rvalid(r_v), .i_s_axi_rready(r_r), .o_s_axi_rdata(r_dat), .o_s_axi_rresp(r_resp),
    .o_wdg_reset(wdg), .o_running(run), .o_count(cnt)
  );

  // ---------------------------------------------------------------------------
  // clock, cycle count, closing
  // ---------------------------------------------------------------------------
  initial forever #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cyc <= cyc + 1;

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // bus tasks: handshakes sampled at the falling edge, where ready is settled
  // ---------------------------------------------------------------------------
  // st holds the ready back until the answer shows, so the slave must keep its answer standing
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input bit st = 1'b0);
    int k;
    logic ta, tw, tb, tv;
    @(posedge i_sys_clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= !st;
    tb = 1'b0;
    for (k = 0; k < 40 && !tb; k++) begin
      @(negedge i_sys_clk);
      ta = aw_v && aw_rdy;
      tw = w_v && w_rdy;
      tb = b_v && b_r;
      tv = b_v;
      b_last = b_resp;
      @(posedge i_sys_clk);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
      if (tv && !tb) b_r <= 1'b1;
    end
    b_r <= 1'b0;
    if (!tb) begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rsp, input bit st = 1'b0);
    int k;
    logic ta, tr, tv;
    @(posedge i_sys_clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= !st;
    tr = 1'b0;
    for (k = 0; k < 40 && !tr; k++) begin
      @(negedge i_sys_clk);
      ta = ar_v && ar_rdy;
      tr = r_v && r_r;
      tv = r_v;
      d = r_dat;
      rsp = r_resp;
      @(posedge i_sys_clk);
      if (ta) ar_v <= 1'b0;
      if (tv && !tr) r_r <= 1'b1;
    end
    r_r <= 1'b0;
    if (!tr) begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e)
  endtask

  // write a setting, see its flag rise, refuse a second write, wait for the flag to fall
  task automatic upd(input logic [4:0] a, input logic [31:0] d, input int b);
    logic [31:0] f;
    logic [1:0]  r;
    int          s, k;
    wr(a, d);
    s = cyc;
    rd(OFF_FLG, f, r);
    `CHK(f[b], 1'b1)
    wr(a, 32'h5);
    for (k = 0; k < 200 && f[b] === 1'b1; k++) begin
      repeat (5) @(posedge i_sys_clk);
      rd(OFF_FLG, f, r);
    end
    `CHK(f[b], 1'b0)
    `CHK(cyc - s <= 1260, 1'b1)
    rdc(a, d);
  endtask

  task automatic do_rst();
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(negedge i_sys_clk);
  endtask

  // hang guard
  initial begin
    #(100 * 60000);
    fail_count++;
    test_done();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(negedge i_sys_clk);
    `CHK(cnt, 12'hfff)
    `CHK(run, 1'b0)
    for (int i = 0; i < 7; i++) begin
      rd(rows[i].a, d, r, i[0]);
      `CHK(d, rows[i].d)
      `CHK(r, rows[i].r)
    end
    // locked registers drop writes and raise no flag
    wr(OFF_RLD, 32'h123, 1'b1);
    `CHK(b_last, RESP_OKAY)
    rdc(OFF_RLD, 32'hfff);
    rdc(OFF_FLG, 32'h0);
    wr(5'h14, 32'h0);
    `CHK(b_last, RESP_SLVERR)
    wr(OFF_KEY, {16'h0, KEY_UNLOCK});
    upd(OFF_DIV, 32'h1, CH_DIV);
    upd(OFF_RLD, 32'h2, CH_RLD);
    wr(OFF_KEY, {16'h0, KEY_RELOAD});
    `CHK(cnt, 12'h002)
    wr(OFF_KEY, {16'h0, KEY_START});
    `CHK(run, 1'b1)
    `CHK(cnt, 12'hfff)
    // divider /8: each step is 8 ticks of 250 cycles, two steps to zero
    wr(OFF_KEY, {16'h0, KEY_RELOAD});
    t0 = cyc;
    for (n = 0; n < 5000 && wdg !== 1'b1; n++) @(negedge i_sys_clk);
    `CHK(wdg, 1'b1)
    `CHK(cyc - t0 > 3000 && cyc - t0 <= 4100, 1'b1)
    do_rst();
    `CHK(wdg, 1'b0)
    // bound change reloads the count; a refresh above the bound fires
    wr(OFF_KEY, {16'h0, KEY_UNLOCK});
    upd(OFF_RLD, 32'h700, CH_RLD);
    upd(OFF_BND, 32'h800, CH_BND);
    `CHK(cnt, 12'h700)
    wr(OFF_KEY, {16'h0, KEY_START});
    wr(OFF_KEY, {16'h0, KEY_RELOAD});
    @(negedge i_sys_clk);
    `CHK(wdg, 1'b1)
    // a key with an unstrobed lane does not match and relocks
    do_rst();
    wr(OFF_KEY, {16'h0, KEY_UNLOCK});
    w_s <= 4'h1;
    wr(OFF_KEY, {16'h0, KEY_UNLOCK});
    w_s <= 4'hf;
    wr(OFF_RLD, 32'h456);
    rdc(OFF_FLG, 32'h0);
    // standby leaves a pending flag alone
    wr(OFF_KEY, {16'h0, KEY_UNLOCK});
    wr(OFF_RLD, 32'h123);
    @(posedge i_sys_clk);
    i_standby <= 1'b1;
    @(posedge i_sys_clk);
    i_standby <= 1'b0;
    rdc(OFF_FLG, 32'h2);
    // a low enable holds the transfer past the three ticks it needs and closes the bus
    i_ce <= 1'b0;
    repeat (1000) @(posedge i_sys_clk);
    `CHK(ar_rdy, 1'b0)
    i_ce <= 1'b1;
    rdc(OFF_FLG, 32'h2);
    test_done();
  end
endmodule

bind iwd_top iwd_top_assertions u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_standby(i_standby),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready), .i_s_axi_awaddr(i_s_axi_awaddr),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready), .i_s_axi_wdata(i_s_axi_wdata),
  .i_s_axi_wstrb(i_s_axi_wstrb), .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
  .o_s_axi_bresp(o_s_axi_bresp), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .i_s_axi_araddr(i_s_axi_araddr), .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
  .o_wdg_reset(o_wdg_reset), .o_running(o_running), .o_count(o_count)
);
